// ===== verilog/drive_stop_pkg.sv
// Constants, register map and carrier types for the start/stop and input assignment block.
// Summary of operation
// R1: 9999 or 8888 decelerates to stop on release.
// R2: 0..100 s: separate starts, coast after delay.
// R3: 1000..1100: coast after setting minus 1000 s.
// R4: 8888, 1000..1100: start plus direction inputs.
// R5: Running output drops when output shuts off; a shutoff or permit input drops only the output and leaves running set.
// R6: Timed coast keeps following frequency command.
// R7: Special stops and jog ignore stop setting.
// R8: Restart during coast begins at minimum frequency.
// R9: Settings writable only while extended view zero.
// R10: Inputs one, two reset to 60, 61.
// R11: Input three resets to code 0.
// R12: Input five resets to code 2.
// R13: Function codes limited to the accepted list.
// R14: Code 60 input one, 61 input two.
// R15: Fixed mapping from codes to command functions.
// R16: Shared function codes combine by logical OR.
// R17: Permit, shutoff within 2 ms, others 20 ms.
// R18: Coast delay counted by derived tick, restarted.
// R19: Out-of-range stop setting writes are dropped.
package drive_stop_pkg;
  localparam int NTERM = 5;
  // Register indices on the plain register port.
  localparam logic [2:0] ADDR_STOP = 3'h0;
  localparam logic [2:0] ADDR_IN1  = 3'h1;
  localparam logic [2:0] ADDR_VIEW = 3'h6;
  localparam logic [2:0] ADDR_STAT = 3'h7;
  // Reset values.
  localparam logic [15:0] RST_STOP = 16'h270F;
  localparam logic [15:0] RST_VIEW = 16'h0000;
  localparam logic [15:0] RST_SEL [NTERM] = '{16'h003C, 16'h003D, 16'h0000, 16'h0001, 16'h0002};
  // Stop method codes and ranges.
  localparam logic [15:0] STOP_DECEL     = 16'h270F;
  localparam logic [15:0] STOP_DECEL_PLN = 16'h22B8;
  localparam logic [15:0] STOP_COAST_MAX = 16'h0064;
  localparam logic [15:0] STOP_PLN_MIN   = 16'h03E8;
  localparam logic [15:0] STOP_PLN_MAX   = 16'h044C;
  // Terminal function codes.
  localparam logic [15:0] FC_LOW     = 16'h0000;
  localparam logic [15:0] FC_MID     = 16'h0001;
  localparam logic [15:0] FC_HIGH    = 16'h0002;
  localparam logic [15:0] FC_JOG     = 16'h0005;
  localparam logic [15:0] FC_PERMIT  = 16'h000A;
  localparam logic [15:0] FC_SHUTOFF = 16'h0018;
  localparam logic [15:0] FC_FWD     = 16'h003C;
  localparam logic [15:0] FC_REV     = 16'h003D;
  localparam logic [15:0] FC_RESET   = 16'h003E;
  localparam logic [15:0] FC_NONE    = 16'h270F;
  // Timing: one-second delay tick and slow input sampling period.
  localparam int CLK_KHZ   = 10000;
  localparam int TICK_MS   = 1000;
  localparam int TICK_CYC  = TICK_MS * CLK_KHZ;
  localparam int FAST_MS   = 2;
  localparam int SLOW_MS   = 10;
  localparam int SLOW_CYC  = SLOW_MS * CLK_KHZ;
  // Status register layout.
  localparam int STAT_RUN  = 3;
  localparam int STAT_OUT  = 4;
  localparam int STAT_REV  = 5;
  localparam int STAT_FUNC = 6;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RUN   = 3'b001,
    ST_DELAY = 3'b011,
    ST_COAST = 3'b010,
    ST_DECEL = 3'b101
  } state_t;
  typedef struct packed {
    logic fwd;
    logic rev;
    logic low;
    logic mid;
    logic high;
    logic jog;
    logic permit;
    logic shutoff;
    logic reset;
  } func_t;
  typedef struct packed {
    logic power_fail;
    logic panel;
    logic comm_err;
  } stop_req_t;
  // Accepted terminal codes; 60 and 61 are tied to the first two terminals.
  function automatic logic code_ok(input logic [15:0] c, input int idx);
    logic ok;
    ok = (c <= 16'h0005) || (c == 16'h0007) || (c == 16'h0008) || (c == 16'h000A) ||
         (c == 16'h000C) || (c == 16'h000E) || (c == 16'h0010) || (c == 16'h0012) ||
         (c == 16'h0018) || (c == 16'h0019) || (c == 16'h003E) || (c == FC_NONE) ||
         ((c >= 16'h0041) && (c <= 16'h0043)) ||
         ((c == FC_FWD) && (idx == 0)) || ((c == FC_REV) && (idx == 1));
    return ok;
  endfunction
  function automatic logic stop_ok(input logic [15:0] c);
    return (c <= STOP_COAST_MAX) || ((c >= STOP_PLN_MIN) && (c <= STOP_PLN_MAX)) ||
           (c == STOP_DECEL) || (c == STOP_DECEL_PLN);
  endfunction
endpackage

// ===== verilog/drive_stop_ctrl.sv
// Start/stop sequencing and input terminal function assignment for the drive.
`timescale 1ns/1ps
module drive_stop_ctrl
  import drive_stop_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYC,
  parameter int P_SLOW_CYCLES = SLOW_CYC
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic [2:0]       i_addr,
  input  wire logic [15:0]      i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [15:0]      o_rdata,
  input  wire logic [NTERM-1:0] i_term,
  input  wire stop_req_t        i_stop_req,
  input  wire logic [15:0]      i_freq_cmd,
  input  wire logic [15:0]      i_min_start_freq,
  input  wire logic             i_at_zero,
  output logic                  o_out_on,
  output logic                  o_running,
  output logic                  o_rev,
  output logic [15:0]           o_freq_ref,
  output logic                  o_seed_load,
  output logic [15:0]           o_seed,
  output func_t                 o_func
);

  logic [15:0]      stop_reg;
  logic [15:0]      view_reg;
  logic [15:0]      sel_reg [NTERM];
  logic [NTERM-1:0] t_s1_reg;
  logic [NTERM-1:0] t_s2_reg;
  logic [NTERM-1:0] slow_reg;
  logic [31:0]      slow_cnt_reg;
  logic [31:0]      tick_cnt_reg;
  logic [15:0]      delay_reg;
  logic [15:0]      delay_next;
  state_t           state_reg;
  state_t           state_next;
  func_t            func;
  logic [NTERM-1:0] h_fwd, h_rev, h_low, h_mid, h_high, h_jog, h_perm, h_shut, h_res, a_perm;
  logic             wr_ok;
  logic             plain_mode;
  logic             decel_mode;
  logic             override;
  logic             start;
  logic             dir_rev;
  logic             tick;
  logic             released;
  logic             restart;
  logic [15:0]      status_word;

  // Settings change only while the extended view select is zero.
  assign wr_ok = i_wr && (view_reg == 16'h0000); // [R9]

  // Stop method register; values outside the accepted set keep the old value.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      stop_reg <= RST_STOP; // [R1]
    end else if (wr_ok && (i_addr == ADDR_STOP) && stop_ok(i_wdata)) begin // [R19]
      stop_reg <= i_wdata;
    end
  end

  // Extended view select is always writable, otherwise nothing could unlock the settings.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      view_reg <= RST_VIEW;
    end else if (i_wr && (i_addr == ADDR_VIEW)) begin
      view_reg <= i_wdata;
    end
  end

  // Terminal function selects with per-terminal code checks.
  always_ff @(posedge i_core_clk) begin
    for (int i = 0; i < NTERM; i++) begin
      if (i_rst) begin
        sel_reg[i] <= RST_SEL[i]; // [R10] [R11] [R12]
      end else if (wr_ok && (i_addr == ADDR_IN1 + 3'(i)) && code_ok(i_wdata, i)) begin // [R13] [R14]
        sel_reg[i] <= i_wdata;
      end
    end
  end

  // Status word built from named field positions; bit 15 stays zero for later use.
  always_comb begin
    status_word                           = 16'h0000;
    status_word[STAT_RUN-1:0]             = state_reg;
    status_word[STAT_RUN]                 = o_running;
    status_word[STAT_OUT]                 = o_out_on;
    status_word[STAT_REV]                 = o_rev;
    status_word[STAT_FUNC+:$bits(func_t)] = func;
  end

  // Read data stands in the cycle after the read strobe; unmapped reads return zero.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_STOP: begin
          o_rdata <= stop_reg;
        end
        ADDR_VIEW: begin
          o_rdata <= view_reg;
        end
        ADDR_STAT: begin
          o_rdata <= status_word;
        end
        default: begin
          if ((i_addr >= ADDR_IN1) && (i_addr < ADDR_IN1 + 3'(NTERM))) begin
            o_rdata <= sel_reg[i_addr - ADDR_IN1];
          end else begin
            o_rdata <= 16'h0000;
          end
        end
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // Contact inputs are asynchronous, so two flops before anything reads them.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      t_s1_reg <= '0;
      t_s2_reg <= '0;
    end else begin
      t_s1_reg <= i_term;
      t_s2_reg <= t_s1_reg;
    end
  end

  // Slow functions are resampled every few ms, which rejects contact bounce
  // yet stays well inside their response budget.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      slow_cnt_reg <= '0;
      slow_reg     <= '0;
    end else if (slow_cnt_reg >= 32'(P_SLOW_CYCLES - 1)) begin
      slow_cnt_reg <= '0;
      slow_reg     <= t_s2_reg; // [R17]
    end else begin
      slow_cnt_reg <= slow_cnt_reg + 32'h0000_0001;
    end
  end

  // Per-terminal code decode; permit and shutoff bypass the slow sampler.
  for (genvar g = 0; g < NTERM; g++) begin : g_term
    assign h_fwd[g]  = (sel_reg[g] == FC_FWD) && slow_reg[g]; // [R15]
    assign h_rev[g]  = (sel_reg[g] == FC_REV) && slow_reg[g];
    assign h_low[g]  = (sel_reg[g] == FC_LOW) && slow_reg[g];
    assign h_mid[g]  = (sel_reg[g] == FC_MID) && slow_reg[g];
    assign h_high[g] = (sel_reg[g] == FC_HIGH) && slow_reg[g];
    assign h_jog[g]  = (sel_reg[g] == FC_JOG) && slow_reg[g];
    assign h_res[g]  = (sel_reg[g] == FC_RESET) && slow_reg[g];
    assign a_perm[g] = (sel_reg[g] == FC_PERMIT);
    assign h_perm[g] = a_perm[g] && t_s2_reg[g]; // [R17]
    assign h_shut[g] = (sel_reg[g] == FC_SHUTOFF) && t_s2_reg[g]; // [R17]
  end

  // Terminals sharing a code are ORed; with no permit terminal the drive is permitted.
  always_comb begin
    func.fwd     = |h_fwd; // [R16]
    func.rev     = |h_rev;
    func.low     = |h_low;
    func.mid     = |h_mid;
    func.high    = |h_high;
    func.jog     = |h_jog;
    func.permit  = ~(|a_perm) | (|h_perm);
    func.shutoff = |h_shut;
    func.reset   = |h_res;
  end

  // Start interpretation and stop method selection.
  always_comb begin
    override   = i_stop_req.power_fail | i_stop_req.panel |
                 i_stop_req.comm_err | func.jog; // [R7]
    plain_mode = !override && ((stop_reg == STOP_DECEL_PLN) ||
                 ((stop_reg >= STOP_PLN_MIN) && (stop_reg <= STOP_PLN_MAX))); // [R4]
    decel_mode = override || (stop_reg == STOP_DECEL) ||
                 (stop_reg == STOP_DECEL_PLN); // [R1] [R7]
    if (plain_mode) begin
      start   = func.fwd;
      dir_rev = func.rev; // [R4]
    end else begin
      start   = func.fwd | func.rev;
      dir_rev = func.rev & ~func.fwd;
    end
  end

  // One-second tick, restarted at each start release so the delay is whole seconds.
  assign released = (state_reg == ST_RUN) && !start;
  assign tick     = (tick_cnt_reg >= 32'(P_TICK_CYCLES - 1));
  always_ff @(posedge i_core_clk) begin
    if (i_rst || released || tick) begin
      tick_cnt_reg <= '0; // [R18]
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  // Sequencer; decel and coast end when the drive core reports zero speed.
  always_comb begin
    state_next = state_reg;
    delay_next = delay_reg;
    restart    = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_RUN;
          restart    = 1'b1;
        end
      end
      ST_RUN: begin
        if (!start) begin
          if (decel_mode) begin
            state_next = ST_DECEL; // [R1]
          end else begin
            // Plain-start range counts from 1000, separate starts from 0.
            delay_next = (stop_reg >= STOP_PLN_MIN) ?
                         (stop_reg - STOP_PLN_MIN) : stop_reg; // [R2] [R3]
            state_next = ST_DELAY;
          end
        end
      end
      ST_DELAY: begin
        // A special stop during the delay ramps down instead of waiting out the timer.
        if (start) begin
          state_next = ST_RUN;
        end else if (override) begin
          state_next = ST_DECEL; // [R7]
        end else if (delay_reg == 16'h0000) begin
          state_next = ST_COAST; // [R2] [R3]
        end else if (tick) begin
          delay_next = delay_reg - 16'h0001; // [R18]
        end
      end
      ST_COAST: begin
        if (start) begin
          state_next = ST_RUN;
          restart    = 1'b1; // [R8]
        end else if (i_at_zero) begin
          state_next = ST_IDLE;
        end
      end
      ST_DECEL: begin
        if (start) begin
          state_next = ST_RUN;
        end else if (i_at_zero) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State and delay registers.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      delay_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      delay_reg <= delay_next;
    end
  end

  // Drive outputs; the run flag drops in the same edge as a state-driven shutoff, but stays set when a shutoff or permit input drops the output.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_running   <= 1'b0;
      o_out_on    <= 1'b0;
      o_rev       <= 1'b0;
      o_freq_ref  <= 16'h0000;
      o_seed_load <= 1'b0;
      o_seed      <= 16'h0000;
      o_func      <= '0;
    end else begin
      o_running   <= (state_next == ST_RUN) || (state_next == ST_DELAY) ||
                     (state_next == ST_DECEL); // [R5]
      o_out_on    <= ((state_next == ST_RUN) || (state_next == ST_DELAY) ||
                     (state_next == ST_DECEL)) && func.permit && !func.shutoff;
      // Direction is held through the delay and the ramp down.
      if (state_next == ST_RUN) begin
        o_rev <= dir_rev;
      end
      // The timed-coast delay keeps tracking the command; decel, coast and idle target zero.
      o_freq_ref  <= ((state_next == ST_RUN) || (state_next == ST_DELAY)) ?
                     i_freq_cmd : 16'h0000; // [R6]
      o_seed_load <= restart;
      if (restart) begin
        o_seed <= i_min_start_freq; // [R8]
      end
      o_func      <= func;
    end
  end

endmodule

// ===== tb/drive_stop_checker.sv
// Port-level concurrent checks for the start/stop and input assignment block.
`timescale 1ns/1ps
module drive_stop_checker
  import drive_stop_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire stop_req_t   i_stop_req,
  input wire logic [15:0] i_freq_cmd,
  input wire logic [15:0] i_min_start_freq,
  input wire logic        i_at_zero,
  input wire logic        o_out_on,
  input wire logic        o_running,
  input wire logic        o_rev,
  input wire logic [15:0] o_freq_ref,
  input wire logic        o_seed_load,
  input wire logic [15:0] o_seed,
  input wire func_t       o_func
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic stop_any;
  // Any of the special stop requests.
  assign stop_any = |i_stop_req;
  // A coast stop drops the bridge no later than the running flag.
  fall_off_a: assert property ($fell(o_running) |-> !o_out_on)
    else $error("running dropped while output on");
  out_run_a: assert property (o_out_on |-> o_running)
    else $error("output on without running");
  // Outside running the target must sit at zero; inside, a nonzero target tracks the command.
  idle_freq_a: assert property (!o_running |-> o_freq_ref == 16'h0000)
    else $error("target nonzero while stopped");
  follow_a: assert property (o_running && o_freq_ref != 16'h0000 |->
                             o_freq_ref == $past(i_freq_cmd))
    else $error("target does not follow command");
  seed_val_a: assert property (o_seed_load |-> o_seed == $past(i_min_start_freq))
    else $error("seed is not the minimum start frequency");
  seed_pulse_a: assert property (o_seed_load |=> !o_seed_load)
    else $error("seed load longer than one cycle");
  seed_on_a: assert property ($rose(o_seed_load) |-> ##[0:1] o_running)
    else $error("seed load without running");
  shutoff_a: assert property (o_func.shutoff |-> ##[0:2] !o_out_on)
    else $error("shutoff did not stop output");
  // Under a special stop the run flag may only drop once the motor has reached zero speed.
  stop_req_a: assert property ($past(stop_any) && $fell(o_running) |->
                               $past(i_at_zero))
    else $error("special stop did not decelerate");
  cover property (o_seed_load);
  cover property ($fell(o_running));
  cover property (o_running && o_rev);
  cover property (o_func.shutoff);
endmodule

// ===== tb/drive_contacts.sv
// External contacts and motor speed feedback facing the start/stop block.
`timescale 1ns/1ps
module drive_contacts
  import drive_stop_pkg::*;
#(
  parameter int P_HOLD = 150
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic [NTERM-1:0] i_press,
  input  wire logic [15:0]      i_freq_ref,
  output logic      [NTERM-1:0] o_term,
  output logic                  o_at_zero
);
  int zero_cnt;
  // Contacts are plain levels; the block does its own synchronising.
  assign o_term = i_press;
  // The motor only reads as stopped after the target has rested at zero for a while,
  // so a restart shortly after a coast begins still finds the motor turning.
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_freq_ref != 16'h0000) begin
      zero_cnt <= 0;
    end else if (zero_cnt < P_HOLD) begin
      zero_cnt <= zero_cnt + 1;
    end
  end
  assign o_at_zero = (zero_cnt >= P_HOLD);
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the start/stop and input assignment block.
`timescale 1ns/1ps
module tb_top
  import drive_stop_pkg::*;
;
  logic clk, rst, wr, rd, at_zero, out_on, running, rev, sload;
  logic [2:0] addr;
  logic [15:0] wdata, rdata, fcmd, minf, fref, seed;
  logic [4:0] term, press;
  stop_req_t sreq;
  func_t func;
  int err_total, check_count, n;
  drive_stop_ctrl #(.P_TICK_CYCLES(20), .P_SLOW_CYCLES(4)) drive_stop_ctrl_i (
    .i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_term(term), .i_stop_req(sreq), .i_freq_cmd(fcmd),
    .i_min_start_freq(minf), .i_at_zero(at_zero), .o_out_on(out_on), .o_running(running),
    .o_rev(rev), .o_freq_ref(fref), .o_seed_load(sload), .o_seed(seed), .o_func(func));
  drive_contacts drive_contacts_i (.i_core_clk(clk), .i_rst(rst), .i_press(press),
    .i_freq_ref(fref), .o_term(term), .o_at_zero(at_zero));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_sim();
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("register", e, rdata);
  endtask
  task automatic pr(input logic [4:0] v);
    @(posedge clk);
    press <= v;
  endtask
  // Bounded wait on running (0), output on (1) or seed load (2); n counts cycles.
  task automatic wt(input int sel, input logic v, output int cnt);
    logic s;
    for (cnt = 1; cnt < 1000; cnt++) begin
      @(posedge clk);
      #1;
      s = (sel == 0) ? running : (sel == 1) ? out_on : sload;
      if (s === v) return;
    end
    err_total++;
    end_sim();
  endtask
  task automatic t_regs();
    rd_reg(3'h0, 16'h270F);
    rd_reg(3'h1, 16'h003C);
    rd_reg(3'h2, 16'h003D);
    rd_reg(3'h3, 16'h0000);
    rd_reg(3'h5, 16'h0002);
    wr_reg(3'h3, 16'h003C);
    wr_reg(3'h3, 16'h0006);
    rd_reg(3'h3, 16'h0000);
    wr_reg(3'h3, 16'h0043);
    rd_reg(3'h3, 16'h0043);
    wr_reg(3'h2, 16'h003C);
    rd_reg(3'h2, 16'h003D);
    wr_reg(3'h0, 16'h0065);
    rd_reg(3'h0, 16'h270F);
    wr_reg(ADDR_VIEW, 16'h0001);
    wr_reg(3'h3, 16'h0000);
    rd_reg(3'h3, 16'h0043);
    wr_reg(ADDR_VIEW, 16'h0000);
    wr_reg(3'h3, 16'h0000);
  endtask
  task automatic t_map();
    wr_reg(3'h3, 16'h0018);
    wr_reg(3'h4, 16'h0018);
    pr(5'b01000);
    repeat (5) @(posedge clk);
    #1;
    chk("shutoff via terminal 4", 1'b1, func.shutoff);
    pr(5'b10000);
    repeat (10) @(posedge clk);
    #1;
    chk("high speed", 1'b1, func.high);
    pr(5'b00000);
    wr_reg(3'h3, 16'h0000);
    wr_reg(3'h4, 16'h0001);
  endtask
  task automatic t_decel();
    pr(5'b00010);
    wt(0, 1'b1, n);
    chk("separate reverse start", 1'b1, rev);
    pr(5'b00000);
    repeat (15) @(posedge clk);
    #1;
    chk("running while ramping", 1'b1, running);
    chk("ramp target", 16'h0000, fref);
    wt(0, 1'b0, n);
  endtask
  task automatic t_coast();
    wr_reg(3'h0, 16'h0002);
    pr(5'b00001);
    wt(0, 1'b1, n);
    @(posedge clk);
    press <= 5'b00000;
    fcmd <= 16'h0800;
    repeat (4) @(posedge clk);
    #1;
    chk("target in delay", 16'h0800, fref);
    wt(1, 1'b0, n);
    chk("two tick coast", 1'b1, (n + 4 >= 40) && (n + 4 <= 52));
    chk("running off at shutoff", 1'b0, running);
    pr(5'b00001);
    wt(2, 1'b1, n);
    chk("restart seed", minf, seed);
    pr(5'b00000);
    wt(0, 1'b0, n);
  endtask
  task automatic t_plain();
    wr_reg(3'h0, 16'h03E9);
    pr(5'b00011);
    wt(0, 1'b1, n);
    chk("direction input", 1'b1, rev);
    pr(5'b00010);
    wt(1, 1'b0, n);
    chk("one tick coast", 1'b1, (n >= 20) && (n <= 32));
    pr(5'b00000);
  endtask
  task automatic t_stopreq();
    wr_reg(3'h0, 16'h03E8);
    for (int k = 0; k < 3; k++) begin
      pr(5'b00001);
      wt(0, 1'b1, n);
      @(posedge clk);
      sreq <= stop_req_t'(3'b001 << k);
      pr(5'b00000);
      repeat (15) @(posedge clk);
      #1;
      chk("special stop ramps", 1'b1, running);
      chk("special stop target", 16'h0000, fref);
      wt(0, 1'b0, n);
      @(posedge clk);
      sreq <= '0;
    end
  endtask
  initial begin
    rst = 1'b1;
    {wr, rd, addr, wdata, press, sreq} = '0;
    fcmd = 16'h1234;
    minf = 16'h0050;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_map();
    t_decel();
    t_coast();
    t_plain();
    t_stopreq();
    end_sim();
  end
endmodule
bind drive_stop_ctrl drive_stop_checker drive_stop_checker_i (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_stop_req(i_stop_req), .i_freq_cmd(i_freq_cmd),
  .i_min_start_freq(i_min_start_freq), .o_out_on(o_out_on), .o_running(o_running),
  .o_rev(o_rev), .o_freq_ref(o_freq_ref), .o_seed_load(o_seed_load), .o_seed(o_seed),
  .o_func(o_func), .i_at_zero(i_at_zero));
